// File: swse_pkg.sv
// Package of opcodes, fields and constants for the subtract and word-store execute block
package swse_pkg;
  localparam logic [5:0] OP_REG_MAJOR = 6'h00;
  localparam logic [5:0] OP_FLOAT_MAJOR = 6'h11;
  localparam logic [5:0] OP_STORE_WORD = 6'h2b;
  localparam logic [5:0] OP_STORE_LEFT = 6'h2a;
  localparam logic [5:0] OP_FP_WORD_STORE = 6'h39;
  localparam logic [5:0] OP_CP2_WORD_STORE = 6'h3a;
  localparam logic [5:0] OP_FP_INDEXED = 6'h13;
  localparam logic [5:0] FN_SUB_TRAP = 6'h22;
  localparam logic [5:0] FN_SUB_MOD = 6'h23;
  localparam logic [5:0] FN_FP_SUB = 6'h01;
  localparam logic [5:0] FN_IDX_DOUBLE_STORE = 6'h0d;
  localparam logic [4:0] FMT_SINGLE = 5'h10;
  localparam logic [4:0] FMT_DOUBLE = 5'h11;
  localparam logic [4:0] FMT_PAIRED = 5'h16;
  // Mode codes handed to the float datapath
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DOUBLE = 2'h1;
  localparam logic [1:0] MODE_PAIRED = 2'h2;
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int FMT_HI = 25;
  localparam int FMT_LO = 21;
  localparam int OFFS_HI = 15;
  localparam int WORD_W = 32;
  localparam int ADDR_LSB_W = 3;
  localparam logic [7:0] MASK_LO_WORD = 8'h0f;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [2:0] DW_ALIGN = 3'h0;
  // Exception cause vector bit positions
  localparam int EX_INT_OVF = 0;
  localparam int EX_ADDR_ERR = 1;
  localparam int EX_TLB_REFILL = 2;
  localparam int EX_TLB_INVALID = 3;
  localparam int EX_TLB_MODIFIED = 4;
  localparam int EX_WATCH = 5;
  localparam int EX_COP_UNUSABLE = 6;
  localparam int EX_RESERVED = 7;
  localparam int EX_FP = 8;
  localparam int EX_W = 9;
  // Float exception flag positions: inexact, underflow, overflow, invalid, unimplemented
  localparam int FX_W = 5;
  typedef enum logic [1:0] {SWSE_IDLE, SWSE_XLATE, SWSE_FPWAIT} swse_state_t;
endpackage

// File: swse_exec.sv
// Execute stage for word subtracts, float subtract and the word-store family
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Overview of operation
// (RULE1) Trapping word subtract decodes register major opcode, function 100010.
// (RULE2) Trapping subtract overflow leaves destination unchanged, raises integer overflow.
// (RULE3) Non-overflowing trapping difference is sign-extended and written to destination.
// (RULE4) Non sign-extended word sources give an unpredictable result.
// (RULE5) Modulo subtract sign-extends the 32-bit difference, never traps.
// (RULE6) Float subtract under float major opcode, function 000001, rounds per control.
// (RULE7) Paired-single subtracts both halves and ORs their exception flags.
// (RULE8) Paired-single result is unpredictable in 16-register float mode.
// (RULE9) Float subtract raises float exceptions, coprocessor-unusable, reserved.
// (RULE10) Invalid registers or wrong formats make float results unpredictable.
// (RULE11) Indexed double store adds base and index, drops low 3 bits.
// (RULE12) Indexed double store never raises address error.
// (RULE13) Indexed double store unpredictable in 16-register float mode.
// (RULE14) Word store address is base plus sign-extended offset, low 32 bits.
// (RULE15) Misaligned word store raises address error and writes nothing.
// (RULE16) Reverse-endian adjusts address bits; lane from bit 2 and cpu order.
// (RULE17) Float word store writes low float word aligned, checks alignment.
// (RULE18) Coprocessor 2 word store uses same addressing and alignment check.
// (RULE19) Stores may raise translation, address and watch; coprocessors more.
// (RULE20) Left-part store writes 1 to 4 top bytes into the aligned word.
// (RULE21) Left-part store sources from the low word of the register.
// (RULE22) Any store exception suppresses the memory write entirely.
// ----------------------------------------------------------------------------
module swse_exec
  import swse_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic issue_valid_i, // Instruction presented
  output logic issue_ready_o, // Block can take an instruction
  input wire logic [31:0] instr_i, // Instruction word
  input wire logic [63:0] src_a_i, // First source or base general register
  input wire logic [63:0] src_b_i, // Second source or index general register
  input wire logic [63:0] store_gr_i, // Store data general register
  input wire logic [63:0] float_fs_i, // First float operand or store data
  input wire logic [63:0] float_ft_i, // Second float operand
  input wire logic [63:0] cp2_reg_i, // Coprocessor 2 store data register
  input wire logic float_major_opcode_usable_i, // Float unit usable
  input wire logic cop2_usable_i, // Coprocessor 2 usable
  input wire logic fr_32_mode_i, // Float unit in 32-register mode
  input wire logic reverse_byte_order_flag_i, // Reverse endian for user mode
  input wire logic cpu_byte_order_flag_i, // CPU big-endian
  output logic gr_we_o, // General register write strobe
  output logic [63:0] gr_wdata_o, // General register write data
  output logic fr_req_o, // Float subtract request to float datapath
  output logic [1:0] fr_mode_o, // 0 single, 1 double, 2 paired
  output logic [63:0] fr_a_o, // Float minuend
  output logic [63:0] fr_b_o, // Float subtrahend
  input wire logic fr_done_i, // Float datapath result ready
  input wire logic [FX_W-1:0] fr_flags_hi_i, // Upper half flags, rounding per control
  input wire logic [FX_W-1:0] fr_flags_lo_i, // Lower half flags
  output logic fp_we_o, // Float register write strobe
  output logic [FX_W-1:0] fp_flags_o, // Float exception flags reported
  output logic xl_req_o, // Translation request
  output logic [63:0] xl_vaddr_o, // Virtual address
  input wire logic xl_done_i, // Translation answer
  input wire logic [63:0] xl_paddr_i, // Physical address
  input wire logic xl_refill_i, // Translation refill fault
  input wire logic xl_invalid_i, // Translation invalid fault
  input wire logic xl_modified_i, // Translation modified fault
  input wire logic xl_watch_i, // Watch match
  output logic mem_we_o, // Memory doubleword store strobe
  output logic [63:0] mem_paddr_o, // Store physical address
  output logic [63:0] mem_wdata_o, // Store doubleword data
  output logic [7:0] mem_be_o, // Byte enables
  output logic exc_o, // Exception pulse
  output logic [EX_W-1:0] exc_cause_o, // Exception cause vector
  output logic unpredictable_o // Result of this instruction is unpredictable
);


  // --------------------------------------------------------------------------
  // State declaration
  // --------------------------------------------------------------------------
  typedef struct packed {
    swse_state_t st;
    logic gr_we;
    logic [63:0] gr_wdata;
    logic fr_req;
    logic [1:0] fr_mode;
    logic [63:0] fr_a;
    logic [63:0] fr_b;
    logic fp_we;
    logic [FX_W-1:0] fp_flags;
    logic xl_req;
    logic [63:0] vaddr;
    logic [63:0] data;
    logic [7:0] be;
    logic sized_word;
    logic cop_store;
    logic mem_we;
    logic [63:0] mem_paddr;
    logic [63:0] mem_wdata;
    logic [7:0] mem_be;
    logic exc;
    logic [EX_W-1:0] cause;
    logic unpred;
  } swse_state_s_t;

  swse_state_s_t s_r;
  swse_state_s_t s_nxt;


  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // A value is a proper word when bits 63..31 all match
  function automatic logic swse_not_word(input logic [63:0] v);
    return !((&v[63:31]) || !(|v[63:31]));
  endfunction

  function automatic logic [63:0] swse_sext32(input logic [31:0] w);
    return {{WORD_W{w[31]}}, w};
  endfunction

  // Place a low word into the lane that virtual bit 2 and cpu order select
  function automatic logic [63:0] swse_lane(input logic [31:0] w, input logic hi);
    return hi ? {w, 32'h0000_0000} : {32'h0000_0000, w};
  endfunction

  // Datapath mode code for a format that has already passed the legality check
  function automatic logic [1:0] swse_fmt_mode(input logic [4:0] f);
    logic [1:0] m;
    if (f == FMT_SINGLE) begin
      m = MODE_SINGLE;
    end else if (f == FMT_DOUBLE) begin
      m = MODE_DOUBLE;
    end else begin
      m = MODE_PAIRED;
    end
    return m;
  endfunction

  // Paired-single reports both halves; the other formats use only the lower result
  function automatic logic [FX_W-1:0] swse_fp_flags(input logic [1:0] mode,
                                                   input logic [FX_W-1:0] hi,
                                                   input logic [FX_W-1:0] lo);
    return (mode == MODE_PAIRED) ? (hi | lo) : lo; // RULE7
  endfunction

  // --------------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------------

  logic [5:0] op;
  logic [5:0] fn;
  logic [4:0] fmt;
  logic [63:0] offs_ea;
  logic [63:0] idx_ea;
  logic [32:0] diff;
  logic [1:0] byte_sel;
  logic lane_hi;
  logic [31:0] left_word;
  logic [3:0] left_be;

  assign op = instr_i[OP_HI:OP_LO];
  assign fn = instr_i[FN_HI:FN_LO];
  assign fmt = instr_i[FMT_HI:FMT_LO];
  assign offs_ea = src_a_i + {{48{instr_i[OFFS_HI]}}, instr_i[OFFS_HI:0]}; // RULE14
  assign idx_ea = src_a_i + src_b_i; // RULE11
  assign diff = {src_a_i[31], src_a_i[31:0]} - {src_b_i[31], src_b_i[31:0]};
  assign byte_sel = offs_ea[1:0] ^ {2{cpu_byte_order_flag_i}};
  assign lane_hi = offs_ea[2] ^ cpu_byte_order_flag_i; // RULE16
  // Top bytes of the low source word shifted down into the lower lanes
  assign left_word = store_gr_i[31:0] >> (8 * (3 - byte_sel)); // RULE20 RULE21
  assign left_be = 4'hf >> (3 - byte_sel); // RULE20


  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Ready only while idle; a busy block ignores any issue request
  assign issue_ready_o = (s_r.st == SWSE_IDLE);

  always_comb begin
    s_nxt = s_r;
    s_nxt.gr_we = 1'b0;
    s_nxt.fp_we = 1'b0;
    s_nxt.mem_we = 1'b0;
    s_nxt.exc = 1'b0;
    s_nxt.fr_req = 1'b0;
    unique case (s_r.st)
      SWSE_IDLE: begin
        if (issue_valid_i) begin
          s_nxt.cause = '0;
          s_nxt.unpred = 1'b0;
          s_nxt.sized_word = 1'b1;
          s_nxt.cop_store = 1'b0;
          s_nxt.vaddr = offs_ea;
          s_nxt.data = swse_lane(store_gr_i[31:0], lane_hi); // RULE14
          s_nxt.be = lane_hi ? ~MASK_LO_WORD : MASK_LO_WORD;
          if (op == OP_REG_MAJOR && (fn == FN_SUB_TRAP || fn == FN_SUB_MOD)) begin
            s_nxt.unpred = swse_not_word(src_a_i) || swse_not_word(src_b_i); // RULE4
            if (fn == FN_SUB_TRAP && diff[32] != diff[31]) begin // RULE1 RULE2
              s_nxt.exc = 1'b1;
              s_nxt.cause[EX_INT_OVF] = 1'b1;
            end else begin
              s_nxt.gr_we = 1'b1; // RULE3 RULE5
              s_nxt.gr_wdata = swse_sext32(diff[31:0]);
            end
          end else if (op == OP_FLOAT_MAJOR && fn == FN_FP_SUB) begin // RULE6
            if (!float_major_opcode_usable_i) begin // RULE9
              s_nxt.exc = 1'b1;
              s_nxt.cause[EX_COP_UNUSABLE] = 1'b1;
            end else if (fmt != FMT_SINGLE && fmt != FMT_DOUBLE && fmt != FMT_PAIRED) begin
              s_nxt.exc = 1'b1;
              s_nxt.cause[EX_RESERVED] = 1'b1; // RULE9
            end else begin
              s_nxt.fr_req = 1'b1;
              s_nxt.fr_mode = swse_fmt_mode(fmt); // RULE6
              s_nxt.fr_a = float_fs_i;
              s_nxt.fr_b = float_ft_i;
              // Odd register numbers are not valid double holders in 16-register mode
              s_nxt.unpred = (fmt == FMT_PAIRED && !fr_32_mode_i) // RULE8
                || (fmt != FMT_SINGLE && !fr_32_mode_i
                    && (instr_i[11] || instr_i[16] || instr_i[6])); // RULE10
              s_nxt.st = SWSE_FPWAIT;
            end
          end else if (op == OP_FP_INDEXED && fn == FN_IDX_DOUBLE_STORE) begin
            if (!float_major_opcode_usable_i) begin
              s_nxt.exc = 1'b1;
              s_nxt.cause[EX_COP_UNUSABLE] = 1'b1;
            end else begin
              s_nxt.vaddr = {idx_ea[63:ADDR_LSB_W], DW_ALIGN}; // RULE11 RULE12
              s_nxt.data = float_fs_i;
              s_nxt.be = MASK_ALL;
              s_nxt.sized_word = 1'b0;
              s_nxt.cop_store = 1'b1;
              s_nxt.unpred = !fr_32_mode_i; // RULE13
              s_nxt.xl_req = 1'b1;
              s_nxt.st = SWSE_XLATE;
            end
          end else if (op == OP_STORE_WORD || op == OP_FP_WORD_STORE
                       || op == OP_CP2_WORD_STORE || op == OP_STORE_LEFT) begin
            if (op == OP_FP_WORD_STORE) begin
              s_nxt.data = swse_lane(float_fs_i[31:0], lane_hi); // RULE17
              s_nxt.cop_store = 1'b1;
            end else if (op == OP_CP2_WORD_STORE) begin
              s_nxt.data = swse_lane(cp2_reg_i[31:0], lane_hi); // RULE18
              s_nxt.cop_store = 1'b1;
            end else if (op == OP_STORE_LEFT) begin
              s_nxt.data = swse_lane(left_word, lane_hi);
              s_nxt.be = lane_hi ? {left_be, 4'h0} : {4'h0, left_be};
              s_nxt.sized_word = 1'b0;
            end
            if ((op == OP_FP_WORD_STORE && !float_major_opcode_usable_i)
                || (op == OP_CP2_WORD_STORE && !cop2_usable_i)) begin // RULE19
              s_nxt.exc = 1'b1;
              s_nxt.cause[EX_COP_UNUSABLE] = 1'b1;
            end else if (op != OP_STORE_LEFT && offs_ea[1:0] != 2'h0) begin // RULE15 RULE17 RULE18
              s_nxt.exc = 1'b1;
              s_nxt.cause[EX_ADDR_ERR] = 1'b1;
            end else begin
              s_nxt.xl_req = 1'b1;
              s_nxt.st = SWSE_XLATE;
            end
          end else begin
            s_nxt.exc = 1'b1;
            s_nxt.cause[EX_RESERVED] = 1'b1;
          end
        end
      end
      SWSE_XLATE: begin
        // Fault lines are only meaningful alongside the answer strobe
        if (xl_done_i) begin
          s_nxt.xl_req = 1'b0;
          s_nxt.st = SWSE_IDLE;
          s_nxt.cause[EX_TLB_REFILL] = xl_refill_i; // RULE19
          s_nxt.cause[EX_TLB_INVALID] = xl_invalid_i;
          s_nxt.cause[EX_TLB_MODIFIED] = xl_modified_i;
          s_nxt.cause[EX_WATCH] = xl_watch_i;
          if (xl_refill_i || xl_invalid_i || xl_modified_i || xl_watch_i) begin
            s_nxt.exc = 1'b1; // RULE22
          end else begin
            s_nxt.mem_we = 1'b1;
            s_nxt.mem_paddr = {xl_paddr_i[63:ADDR_LSB_W],
                               xl_paddr_i[2:0] ^ {reverse_byte_order_flag_i, 2'h0}}; // RULE16
            s_nxt.mem_wdata = s_r.data;
            s_nxt.mem_be = s_r.be;
          end
        end
      end
      SWSE_FPWAIT: begin
        if (fr_done_i) begin
          s_nxt.st = SWSE_IDLE;
          s_nxt.fp_we = 1'b1;
          s_nxt.fp_flags = swse_fp_flags(s_r.fr_mode, fr_flags_hi_i, fr_flags_lo_i); // RULE7
          if (swse_fp_flags(s_r.fr_mode, fr_flags_hi_i, fr_flags_lo_i) != '0) begin
            s_nxt.exc = 1'b1;
            s_nxt.cause[EX_FP] = 1'b1; // RULE9
          end
        end
      end
      default: s_nxt.st = SWSE_IDLE;
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '{st: SWSE_IDLE, be: MASK_NONE, mem_be: MASK_NONE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Every output except issue_ready_o is a register bit, so the far side never sees decode glitches on them
  assign gr_we_o = s_r.gr_we;
  assign gr_wdata_o = s_r.gr_wdata;
  assign fr_req_o = s_r.fr_req;
  assign fr_mode_o = s_r.fr_mode;
  assign fr_a_o = s_r.fr_a;
  assign fr_b_o = s_r.fr_b;
  assign fp_we_o = s_r.fp_we;
  assign fp_flags_o = s_r.fp_flags;
  assign xl_req_o = s_r.xl_req;
  assign xl_vaddr_o = s_r.vaddr;
  assign mem_we_o = s_r.mem_we;
  assign mem_paddr_o = s_r.mem_paddr;
  assign mem_wdata_o = s_r.mem_wdata;
  assign mem_be_o = s_r.mem_be;
  assign exc_o = s_r.exc;
  assign exc_cause_o = s_r.cause;
  assign unpredictable_o = s_r.unpred;

endmodule // swse_exec

// File: swse_assertions.sv
// Port-level assertions for the subtract and word-store execute block
`timescale 1ns/1ns
module swse_assertions
  import swse_pkg::*;
(
  input wire logic core_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic issue_valid_i, // Issue
  input wire logic issue_ready_o, // Ready
  input wire logic [31:0] instr_i, // Instruction
  input wire logic [63:0] src_a_i, // Source a
  input wire logic [63:0] src_b_i, // Source b
  input wire logic reverse_byte_order_flag_i, // Reverse order
  input wire logic gr_we_o, // Write
  input wire logic [63:0] gr_wdata_o, // Write data
  input wire logic exc_o, // Exception
  input wire logic [EX_W-1:0] exc_cause_o, // Cause
  input wire logic xl_req_o, // Translate
  input wire logic xl_done_i, // Answer
  input wire logic [63:0] xl_paddr_i, // Paddr
  input wire logic xl_refill_i, // Fault
  input wire logic xl_invalid_i, // Fault
  input wire logic xl_modified_i, // Fault
  input wire logic xl_watch_i, // Fault
  input wire logic mem_we_o, // Store
  input wire logic [63:0] mem_paddr_o // Store address
);
  // ----
  // Word difference at issue; bit 32 unlike bit 31 means overflow
  // ----
  logic [32:0] diff;
  logic rtake;
  logic flt;
  assign diff = {src_a_i[31], src_a_i[31:0]} - {src_b_i[31], src_b_i[31:0]};
  assign rtake = issue_valid_i && issue_ready_o && instr_i[OP_HI:OP_LO] == OP_REG_MAJOR;
  assign flt = xl_refill_i | xl_invalid_i | xl_modified_i | xl_watch_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_sub_overflow:
    assert property (rtake && instr_i[5:0] == FN_SUB_TRAP && diff[32] != diff[31]
      |=> exc_o && exc_cause_o[EX_INT_OVF] && !gr_we_o) else $error("overflow not trapped");
  a_sub_result:
    assert property (rtake && instr_i[5:0] == FN_SUB_TRAP && diff[32] == diff[31] |=> gr_we_o
      && !exc_o && gr_wdata_o == {{32{$past(diff[31])}}, $past(diff[31:0])})
      else $error("trapping difference wrong");
  a_modulo_result:
    assert property (rtake && instr_i[5:0] == FN_SUB_MOD |=> gr_we_o && !exc_o
      && gr_wdata_o == {{32{$past(diff[31])}}, $past(diff[31:0])})
      else $error("modulo difference wrong");
  a_fault_drop:
    assert property (xl_req_o && xl_done_i && flt |=> exc_o && !mem_we_o)
      else $error("store written despite fault");
  a_store_addr:
    assert property (xl_req_o && xl_done_i && !flt |=> mem_we_o && mem_paddr_o ==
      ($past(xl_paddr_i) ^ {61'h0, $past(reverse_byte_order_flag_i), 2'h0}))
      else $error("store address wrong");
  a_addr_err_early:
    assert property (exc_o && exc_cause_o[EX_ADDR_ERR] |-> !mem_we_o && !$past(xl_req_o))
      else $error("misaligned store translated");
  a_xl_hold:
    assert property (xl_req_o && !xl_done_i |=> xl_req_o) else $error("request dropped");
  a_xl_release:
    assert property (xl_req_o && xl_done_i |=> !xl_req_o && issue_ready_o)
      else $error("request not released");
endmodule // swse_assertions
bind swse_exec swse_assertions u_swse_chk (.core_clk_i, .rst_n_i, .issue_valid_i,
  .issue_ready_o, .instr_i, .src_a_i, .src_b_i, .reverse_byte_order_flag_i, .gr_we_o,
  .gr_wdata_o, .exc_o, .exc_cause_o, .xl_req_o, .xl_done_i, .xl_paddr_i, .xl_refill_i,
  .xl_invalid_i, .xl_modified_i, .xl_watch_i, .mem_we_o, .mem_paddr_o);

// File: swse_mem_model.sv
// Translation and float datapath model facing the execute block
`timescale 1ns/1ns
module swse_mem_model (
  input wire logic core_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic xl_req_i, // Translate request
  input wire logic [63:0] xl_vaddr_i, // Virtual address
  input wire logic [3:0] xl_dly_i, // Answer delay
  input wire logic [3:0] xl_fault_i, // Refill, invalid, modified, watch
  input wire logic fr_req_i, // Float request
  output logic xl_done_o, // Answer
  output logic [63:0] xl_paddr_o, // Physical address
  output logic [3:0] xl_fault_o, // Faults
  output logic fr_done_o // Float answer
);
  // ----
  // Outside an answer the lines show inverted values so stale data never matches
  // ----
  localparam logic [63:0] PA_OFS = 64'h0000_0000_1000_0000;
  logic [3:0] cnt_r;
  logic served_r;
  assign xl_paddr_o = xl_done_o ? xl_vaddr_i ^ PA_OFS : ~xl_vaddr_i;
  assign xl_fault_o = xl_done_o ? xl_fault_i : ~xl_fault_i;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
      served_r <= 1'b0;
      xl_done_o <= 1'b0;
      fr_done_o <= 1'b0;
    end else begin
      xl_done_o <= 1'b0;
      fr_done_o <= fr_req_i;
      if (!xl_req_i) begin
        cnt_r <= 4'h0;
        served_r <= 1'b0;
      end else if (!served_r) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == xl_dly_i) begin
          xl_done_o <= 1'b1;
          served_r <= 1'b1;
        end
      end
    end
  end
endmodule // swse_mem_model

// File: testbench.sv
// Self-checking testbench for the subtract and word-store execute block
`timescale 1ns/1ns
module testbench import swse_pkg::*;;
  typedef struct {
    logic [31:0] ins;
    logic [63:0] a;
    logic [63:0] b;
    logic [3:0] s;
    logic [EX_W-1:0] c;
    logic [63:0] v;
    logic [63:0] p;
    logic [7:0] be;
  } swse_row_t;
  logic core_clk_i, rst_n_i, issue_valid_i, issue_ready_o, float_major_opcode_usable_i, cop2_usable_i;
  logic fr_32_mode_i, reverse_byte_order_flag_i, cpu_byte_order_flag_i, gr_we_o, fr_req_o;
  logic fr_done_i, fp_we_o, xl_req_o, xl_done_i, xl_refill_i, xl_invalid_i, xl_modified_i;
  logic xl_watch_i, mem_we_o, exc_o, unpredictable_o;
  logic [1:0] fr_mode_o;
  logic [3:0] xl_dly, xl_flt;
  logic [7:0] mem_be_o;
  logic [FX_W-1:0] fr_flags_hi_i, fr_flags_lo_i, fp_flags_o;
  logic [EX_W-1:0] exc_cause_o;
  logic [31:0] instr_i;
  logic [63:0] src_a_i, src_b_i, store_gr_i, float_fs_i, float_ft_i, cp2_reg_i, gr_wdata_o;
  logic [63:0] fr_a_o, fr_b_o, xl_vaddr_o, xl_paddr_i, mem_paddr_o, mem_wdata_o;
  int error_cnt = 0;
  int samples_checked = 0;
  swse_row_t rows[11];
  swse_exec dut (.*);
  swse_mem_model u_far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .xl_req_i(xl_req_o),
    .xl_vaddr_i(xl_vaddr_o), .xl_dly_i(xl_dly), .xl_fault_i(xl_flt), .fr_req_i(fr_req_o),
    .xl_done_o(xl_done_i), .xl_paddr_o(xl_paddr_i),
    .xl_fault_o({xl_refill_i, xl_invalid_i, xl_modified_i, xl_watch_i}), .fr_done_o(fr_done_i));
  always #4 core_clk_i = ~core_clk_i;
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] ri(input logic [5:0] fn);
    return {OP_REG_MAJOR, 5'h01, 5'h02, 5'h03, 5'h00, fn};
  endfunction
  function automatic logic [31:0] st(input logic [5:0] op, input logic [15:0] off);
    return {op, 5'h04, 5'h05, off};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Issue one instruction and compare whatever answer ends it
  task automatic run(input swse_row_t r);
    int n;
    n = 0;
    issue_valid_i = 1'b1;
    instr_i = r.ins;
    src_a_i = r.a;
    src_b_i = r.b;
    @(negedge core_clk_i);
    issue_valid_i = 1'b0;
    while (!(gr_we_o | exc_o | mem_we_o | fp_we_o) && n < 40) begin
      @(negedge core_clk_i);
      n++;
    end
    chk({gr_we_o, exc_o, mem_we_o, fp_we_o}, r.s);
    chk(exc_o ? exc_cause_o : 9'h0, r.c);
    chk(gr_we_o ? gr_wdata_o : mem_we_o ? mem_wdata_o : fp_we_o ? fp_flags_o : 64'h0, r.v);
    chk(mem_we_o ? {mem_be_o, mem_paddr_o[55:0]} : 64'h0, {r.be, r.p[55:0]});
    @(negedge core_clk_i);
    $display("case %h done", r.ins);
  endtask
  initial begin
    repeat (5000) @(posedge core_clk_i);
    error_cnt++;
    report_and_stop();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    swse_row_t r;
    rows = '{
      '{ri(FN_SUB_TRAP), 64'h5, 64'h7, 4'h8, 9'h0, 64'hffff_ffff_ffff_fffe, 64'h0, 8'h0},
      '{ri(FN_SUB_TRAP), 64'h7fff_ffff, 64'hffff_ffff_ffff_ffff, 4'h4, 9'h001, 64'h0, 64'h0,
        8'h0},
      '{ri(FN_SUB_MOD), 64'h7fff_ffff, 64'hffff_ffff_ffff_ffff, 4'h8, 9'h0,
        64'hffff_ffff_8000_0000, 64'h0, 8'h0},
      '{st(OP_STORE_WORD, 16'hfffc), 64'h108, 64'h0, 4'h2, 9'h0, 64'h5566_7788_0000_0000,
        64'h1000_0104, 8'hf0},
      '{st(OP_STORE_WORD, 16'h0002), 64'h100, 64'h0, 4'h4, 9'h002, 64'h0, 64'h0, 8'h0},
      '{st(OP_FP_WORD_STORE, 16'h0008), 64'h200, 64'h0, 4'h2, 9'h0, 64'h0102_0304,
        64'h1000_0208, 8'h0f},
      '{st(OP_CP2_WORD_STORE, 16'h000c), 64'h200, 64'h0, 4'h2, 9'h0, 64'h90ab_cdef_0000_0000,
        64'h1000_020c, 8'hf0},
      '{st(OP_CP2_WORD_STORE, 16'h000d), 64'h200, 64'h0, 4'h4, 9'h002, 64'h0, 64'h0, 8'h0},
      '{st(OP_STORE_LEFT, 16'h0001), 64'h300, 64'h0, 4'h2, 9'h0, 64'h5566, 64'h1000_0301,
        8'h03},
      '{{OP_FP_INDEXED, 5'h04, 5'h05, 10'h0, FN_IDX_DOUBLE_STORE}, 64'h400, 64'h7, 4'h2, 9'h0,
        64'haabb_ccdd_0102_0304, 64'h1000_0400, 8'hff},
      '{{OP_FLOAT_MAJOR, FMT_PAIRED, 5'h02, 5'h04, 5'h06, FN_FP_SUB}, 64'h0, 64'h0, 4'h5,
        9'h100, 64'h05, 64'h0, 8'h0}};
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    issue_valid_i = 1'b0;
    instr_i = 32'h0;
    src_a_i = 64'h0;
    src_b_i = 64'h0;
    store_gr_i = 64'h1122_3344_5566_7788;
    float_fs_i = 64'haabb_ccdd_0102_0304;
    float_ft_i = 64'h3ff0_0000_0000_0000;
    cp2_reg_i = 64'h0506_0708_90ab_cdef;
    {float_major_opcode_usable_i, cop2_usable_i, fr_32_mode_i} = 3'h7;
    {reverse_byte_order_flag_i, cpu_byte_order_flag_i} = 2'h0;
    fr_flags_hi_i = 5'h01;
    fr_flags_lo_i = 5'h04;
    xl_dly = 4'h0;
    xl_flt = 4'h0;
    repeat (8) @(negedge core_clk_i);
    chk({issue_ready_o, gr_we_o, xl_req_o, mem_we_o, exc_o}, 64'h10);
    rst_n_i = 1'b1;
    foreach (rows[i]) run(rows[i]);
    // Slow answers carrying each translation fault
    xl_dly = 4'h3;
    for (int i = 0; i < 4; i++) begin
      r = '{rows[3].ins, 64'h108, 64'h0, 4'h4, 9'h020 >> i, 64'h0, 64'h0, 8'h0};
      xl_flt = 4'h1 << i;
      run(r);
    end
    {xl_dly, xl_flt} = 8'h00;
    {reverse_byte_order_flag_i, cpu_byte_order_flag_i} = 2'h3;
    r = '{rows[3].ins, 64'h108, 64'h0, 4'h2, 9'h0, 64'h5566_7788, 64'h1000_0100, 8'h0f};
    run(r);
    r = '{rows[8].ins, 64'h300, 64'h0, 4'h2, 9'h0, 64'h0055_6677_0000_0000, 64'h1000_0305, 8'h70};
    run(r);
    {reverse_byte_order_flag_i, cpu_byte_order_flag_i, float_major_opcode_usable_i, cop2_usable_i} = 4'h0;
    r = '{rows[5].ins, 64'h200, 64'h0, 4'h4, 9'h040, 64'h0, 64'h0, 8'h0};
    run(r);
    r.ins = rows[6].ins;
    run(r);
    {float_major_opcode_usable_i, cop2_usable_i, fr_32_mode_i} = 3'h6;
    run(rows[9]);
    chk(xl_vaddr_o, 64'h400);
    chk(unpredictable_o, 64'h1);
    {fr_flags_hi_i, fr_flags_lo_i, fr_32_mode_i} = 11'h001;
    r = '{rows[10].ins, 64'h0, 64'h0, 4'h1, 9'h0, 64'h0, 64'h0, 8'h0};
    run(r);
    chk(fr_mode_o, 64'h2);
    chk(fr_a_o, 64'haabb_ccdd_0102_0304);
    chk(fr_b_o, 64'h3ff0_0000_0000_0000);
    // Reset in mid-translation must leave the block idle
    xl_dly = 4'hf;
    issue_valid_i = 1'b1;
    instr_i = rows[3].ins;
    src_a_i = 64'h108;
    @(negedge core_clk_i);
    issue_valid_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk({issue_ready_o, xl_req_o}, 64'h1);
    rst_n_i = 1'b0;
    @(negedge core_clk_i);
    chk({issue_ready_o, xl_req_o, mem_we_o}, 64'h4);
    rst_n_i = 1'b1;
    xl_dly = 4'h0;
    run(rows[0]);
    chk(unpredictable_o, 64'h0);
    $display("hand tests done");
    report_and_stop();
  end
endmodule // testbench
